// >>> bench/cpu_trace_trap_lowpower_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctt_defines.svh"

`define CHK(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            mismatches++; \
            $display("unexpected at %0t: got %h exp %h", $time, got, exp); \
        end \
    end

module cpu_trace_trap_lowpower_bench
    import ctt_pkg::*;
;
    logic clk;
    logic reset_n;
    logic instr_done;
    logic [15:0] instr_opcode;
    logic instr_legal;
    logic instr_flow_change;
    ctt_trace_mode_t trace_mode;
    logic low_power_stop_instr;
    logic [2:0] stop_level;
    logic [2:0] irq_level_pin;
    logic core_standby;
    logic wake_pulse;
    logic table_interpolate_instr;
    ctt_tbl_variant_t tbl_variant;
    logic [15:0] tbl_y0;
    logic [15:0] tbl_y1;
    logic [7:0] tbl_frac;
    logic [15:0] tbl_result;
    logic tbl_done;
    logic exc_req;
    logic [7:0] exc_vector;
    logic bkpt_ack;
    int mismatches = 0;
    int n_checks = 0;
    int cycles = 0;

    ctt_exception_unit uut (
        .clk(clk),
        .reset_n(reset_n),
        .instr_done(instr_done),
        .instr_opcode(instr_opcode),
        .instr_legal(instr_legal),
        .instr_flow_change(instr_flow_change),
        .trace_mode(trace_mode),
        .low_power_stop_instr(low_power_stop_instr),
        .stop_level(stop_level),
        .irq_level_pin(irq_level_pin),
        .core_standby(core_standby),
        .wake_pulse(wake_pulse),
        .table_interpolate_instr(table_interpolate_instr),
        .tbl_variant(tbl_variant),
        .tbl_y0(tbl_y0),
        .tbl_y1(tbl_y1),
        .tbl_frac(tbl_frac),
        .tbl_result(tbl_result),
        .tbl_done(tbl_done),
        .exc_req(exc_req),
        .exc_vector(exc_vector),
        .bkpt_ack(bkpt_ack)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (mismatches == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // generous ceiling; the whole run needs about 80 cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    // one retiring instruction, answer judged one edge later
    task automatic retire(input logic [15:0] op, input logic legal, input logic flow,
                          input ctt_trace_mode_t mode, input logic req,
                          input logic [7:0] vec, input logic bk);
        @(posedge clk);
        instr_done <= 1'b1;
        instr_opcode <= op;
        instr_legal <= legal;
        instr_flow_change <= flow;
        trace_mode <= mode;
        @(posedge clk);
        instr_done <= 1'b0;
        #1;
        `CHK(exc_req, req)
        `CHK(bkpt_ack, bk)
        if (req)
            `CHK(exc_vector, vec)
    endtask

    task automatic interp(input ctt_tbl_variant_t v, input logic [15:0] a,
                          input logic [15:0] b, input logic [7:0] f, input logic [15:0] exp);
        @(posedge clk);
        table_interpolate_instr <= 1'b1;
        tbl_variant <= v;
        tbl_y0 <= a;
        tbl_y1 <= b;
        tbl_frac <= f;
        @(posedge clk);
        table_interpolate_instr <= 1'b0;
        #1;
        `CHK(tbl_done, 1'b1)
        `CHK(tbl_result, exp)
    endtask

    task automatic check_reset();
        `CHK(core_standby, 1'b0)
        `CHK(exc_req, 1'b0)
        `CHK(exc_vector, `CTT_VEC_RESET)
        `CHK(tbl_result, `CTT_DATA_RESET)
        `CHK(wake_pulse, 1'b0)
        `CHK(bkpt_ack, 1'b0)
        `CHK(tbl_done, 1'b0)
    endtask

    // window edges 4847 and 4850 must not count as breakpoints
    task automatic test_breakpoint();
        logic hit;
        for (int i = 16'h4847; i <= 16'h4850; i++)
        begin
            hit = (i >= 16'h4848) && (i <= 16'h484f);
            retire(16'(i), 1'b1, 1'b0, trace_off, hit, `CTT_VEC_ILLEGAL, hit);
        end
        retire(16'h484f, 1'b1, 1'b1, trace_all, 1'b1, `CTT_VEC_ILLEGAL, 1'b1);
    endtask

    task automatic test_faults();
        retire(16'h4afc, 1'b0, 1'b0, trace_off, 1'b1, `CTT_VEC_ILLEGAL, 1'b0);
        retire(16'ha123, 1'b1, 1'b0, trace_off, 1'b1, `CTT_VEC_ALINE, 1'b0);
        retire(16'hf000, 1'b0, 1'b0, trace_off, 1'b1, `CTT_VEC_FLINE, 1'b0);
        retire(16'ha000, 1'b1, 1'b1, trace_all, 1'b1, `CTT_VEC_ALINE, 1'b0);
        retire(16'hffff, 1'b1, 1'b0, trace_all, 1'b1, `CTT_VEC_FLINE, 1'b0);
    endtask

    task automatic test_trace();
        retire(16'h4e71, 1'b1, 1'b1, trace_off, 1'b0, 8'h00, 1'b0);
        retire(16'h4e71, 1'b1, 1'b0, trace_all, 1'b1, `CTT_VEC_TRACE, 1'b0);
        retire(16'h4e71, 1'b1, 1'b0, trace_flow, 1'b0, 8'h00, 1'b0);
        retire(16'h6000, 1'b1, 1'b1, trace_flow, 1'b1, `CTT_VEC_TRACE, 1'b0);
        retire(16'h6000, 1'b1, 1'b1, ctt_trace_mode_t'(2'h3), 1'b0, 8'h00, 1'b0);
    endtask

    // a lower pending level must not wake the core
    task automatic test_stop();
        @(posedge clk);
        low_power_stop_instr <= 1'b1;
        stop_level <= 3'h5;
        irq_level_pin <= 3'h4;
        @(posedge clk);
        low_power_stop_instr <= 1'b0;
        #1;
        `CHK(core_standby, 1'b1)
        repeat (8) @(posedge clk);
        #1;
        `CHK(core_standby, 1'b1)
        @(posedge clk);
        irq_level_pin <= 3'h5;
        // two synchroniser edges, then the wake edge
        repeat (2) @(posedge clk);
        #1;
        `CHK(core_standby, 1'b1)
        @(posedge clk);
        #1;
        `CHK(wake_pulse, 1'b1)
        `CHK(core_standby, 1'b0)
        @(posedge clk);
        irq_level_pin <= 3'h0;
        stop_level <= 3'h7;
        low_power_stop_instr <= 1'b1;
        @(posedge clk);
        low_power_stop_instr <= 1'b0;
        #1;
        `CHK(wake_pulse, 1'b0)
        `CHK(core_standby, 1'b1)
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        #1;
        `CHK(core_standby, 1'b0)
        @(posedge clk);
        reset_n <= 1'b1;
    endtask

    task automatic test_table();
        interp(table_interp_signed_round, 16'h0000, 16'hfffd, 8'h80, 16'hffff);
        interp(table_interp_signed_noround, 16'h0000, 16'hfffd, 8'h80, 16'hfffe);
        interp(table_interp_unsigned_round, 16'h0000, 16'hfffd, 8'h80, 16'h7fff);
        interp(table_interp_unsigned_noround, 16'h0000, 16'hfffd, 8'h80, 16'h7ffe);
        interp(table_interp_signed_noround, 16'h0100, 16'hff00, 8'h40, 16'h0080);
        interp(table_interp_unsigned_noround, 16'h0100, 16'hff00, 8'h40, 16'h4080);
        interp(table_interp_signed_round, 16'h1234, 16'h7000, 8'h00, 16'h1234);
    endtask

    initial
    begin
        reset_n = 1'b0;
        instr_done = 1'b0;
        instr_opcode = 16'h0000;
        instr_legal = 1'b1;
        instr_flow_change = 1'b0;
        trace_mode = trace_off;
        low_power_stop_instr = 1'b0;
        stop_level = 3'h0;
        irq_level_pin = 3'h0;
        table_interpolate_instr = 1'b0;
        tbl_variant = table_interp_signed_round;
        tbl_y0 = 16'h0000;
        tbl_y1 = 16'h0000;
        tbl_frac = 8'h00;
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        check_reset();
        test_breakpoint();
        test_faults();
        test_trace();
        test_stop();
        test_table();
        tally_and_finish();
    end
endmodule

`default_nettype wire

// >>> pkg/ctt_defines.svh
`ifndef CTT_DEFINES_SVH
`define CTT_DEFINES_SVH

// breakpoint opcode window: base with low three bits free
`define CTT_BKPT_BASE 16'h4848
`define CTT_BKPT_MASK 16'hfff8

// opcode line codes in bits 15:12
`define CTT_LINE_POS 12
`define CTT_LINE_A 4'ha
`define CTT_LINE_F 4'hf

// exception vector numbers
`define CTT_VEC_ILLEGAL 8'h04
`define CTT_VEC_TRACE 8'h09
`define CTT_VEC_ALINE 8'h0a
`define CTT_VEC_FLINE 8'h0b
`define CTT_VEC_RESET 8'h00

// interpolation: 8-bit fraction, half an lsb for rounding
`define CTT_FRAC_POS 8
`define CTT_ROUND_HALF 27'h0000080

// reset values
`define CTT_LEVEL_RESET 3'h0
`define CTT_DATA_RESET 16'h0000

`endif

// >>> pkg/ctt_pkg.sv
package ctt_pkg;

    typedef enum logic [1:0] {
        trace_off,
        trace_all,
        trace_flow
    } ctt_trace_mode_t;

    typedef enum logic [1:0] {
        table_interp_signed_round,
        table_interp_signed_noround,
        table_interp_unsigned_round,
        table_interp_unsigned_noround
    } ctt_tbl_variant_t;

    typedef enum logic {
        pwr_run,
        pwr_standby
    } ctt_power_t;

endpackage

// >>> src/ctt_exception_unit.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctt_defines.svh"

module ctt_exception_unit
    import ctt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // retiring instruction from the sequencer
    input wire logic instr_done,
    input wire logic [15:0] instr_opcode,
    input wire logic instr_legal,
    input wire logic instr_flow_change,
    // core control trace field
    input wire ctt_trace_mode_t trace_mode,
    // low power stop
    input wire logic low_power_stop_instr,
    input wire logic [2:0] stop_level,
    input wire logic [2:0] irq_level_pin,
    output logic core_standby,
    output logic wake_pulse,
    // table lookup and interpolate
    input wire logic table_interpolate_instr,
    input wire ctt_tbl_variant_t tbl_variant,
    input wire logic [15:0] tbl_y0,
    input wire logic [15:0] tbl_y1,
    input wire logic [7:0] tbl_frac,
    output logic [15:0] tbl_result,
    output logic tbl_done,
    // exception request to the sequencer
    output logic exc_req,
    output logic [7:0] exc_vector,
    output logic bkpt_ack
);

    logic [2:0] irq_meta_reg;
    logic [2:0] irq_sync_reg;
    ctt_power_t power_reg;
    ctt_power_t power_next;
    logic [2:0] stop_level_reg;
    logic wake_reg;
    logic exc_req_reg;
    logic exc_req_next;
    logic [7:0] exc_vector_reg;
    logic [7:0] exc_vector_next;
    logic bkpt_reg;
    logic bkpt_next;
    logic bkpt_hit;
    logic aline_hit;
    logic fline_hit;
    logic trace_hit;
    logic wake_ok;

    function automatic logic [3:0] opcode_line(input logic [15:0] op);
        opcode_line = op[`CTT_LINE_POS +: 4];
    endfunction

    // interrupt level comes from pins: two flops before use
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irq_meta_reg <= `CTT_LEVEL_RESET;
            irq_sync_reg <= `CTT_LEVEL_RESET;
        end
        else
        begin
            irq_meta_reg <= irq_level_pin;
            irq_sync_reg <= irq_meta_reg;
        end
    end

    assign wake_ok = irq_sync_reg >= stop_level_reg;

    always_comb
    begin
        power_next = power_reg;
        unique case (power_reg)
            pwr_run:
            begin
                if (low_power_stop_instr)
                begin
                    power_next = pwr_standby;
                end
            end
            pwr_standby:
            begin
                // wake on equal or higher level
                if (wake_ok)
                begin
                    power_next = pwr_run;
                end
            end
        endcase
    end

    // reset is the other way out of standby: it returns the state to run
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            power_reg <= pwr_run;
        end
        else
        begin
            power_reg <= power_next;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            stop_level_reg <= `CTT_LEVEL_RESET;
        end
        else if (power_reg == pwr_run && low_power_stop_instr)
        begin
            stop_level_reg <= stop_level;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            wake_reg <= 1'b0;
        end
        else
        begin
            wake_reg <= (power_reg == pwr_standby) && (power_next == pwr_run);
        end
    end

    assign core_standby = (power_reg == pwr_standby);
    assign wake_pulse = wake_reg;

    // exception selection; breakpoint wins since it is also an illegal opcode
    always_comb
    begin
        bkpt_hit = (instr_opcode & `CTT_BKPT_MASK) == `CTT_BKPT_BASE;
        aline_hit = opcode_line(instr_opcode) == `CTT_LINE_A;
        fline_hit = opcode_line(instr_opcode) == `CTT_LINE_F;
        // three trace settings, spare code means off
        unique case (trace_mode)
            trace_all: trace_hit = 1'b1;
            trace_flow: trace_hit = instr_flow_change;
            default: trace_hit = 1'b0;
        endcase
        exc_req_next = 1'b0;
        exc_vector_next = exc_vector_reg;
        bkpt_next = 1'b0;
        if (instr_done)
        begin
            if (bkpt_hit)
            begin
                exc_req_next = 1'b1;
                exc_vector_next = `CTT_VEC_ILLEGAL;
                bkpt_next = 1'b1;
            end
            else if (aline_hit)
            begin
                exc_req_next = 1'b1;
                exc_vector_next = `CTT_VEC_ALINE;
            end
            else if (fline_hit)
            begin
                exc_req_next = 1'b1;
                exc_vector_next = `CTT_VEC_FLINE;
            end
            else if (!instr_legal)
            begin
                exc_req_next = 1'b1;
                exc_vector_next = `CTT_VEC_ILLEGAL;
            end
            else if (trace_hit)
            begin
                exc_req_next = 1'b1;
                exc_vector_next = `CTT_VEC_TRACE;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            exc_req_reg <= 1'b0;
            bkpt_reg <= 1'b0;
        end
        else
        begin
            exc_req_reg <= exc_req_next;
            bkpt_reg <= bkpt_next;
        end
    end

    // vector holds after the pulse so the sequencer may read it late
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            exc_vector_reg <= `CTT_VEC_RESET;
        end
        else
        begin
            exc_vector_reg <= exc_vector_next;
        end
    end

    assign exc_req = exc_req_reg;
    assign exc_vector = exc_vector_reg;
    assign bkpt_ack = bkpt_reg;

    ctt_table_interp u_interp (
        .clk(clk),
        .reset_n(reset_n),
        .start(table_interpolate_instr),
        .variant(tbl_variant),
        .y0(tbl_y0),
        .y1(tbl_y1),
        .frac(tbl_frac),
        .result(tbl_result),
        .done(tbl_done)
    );

    stop_enter_a: assert property (@(posedge clk) disable iff (!reset_n)
        !core_standby && low_power_stop_instr |=> core_standby)
        else $error("stop instruction did not enter standby");

    stop_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        core_standby && irq_sync_reg < stop_level_reg |=> core_standby && !wake_pulse)
        else $error("standby left without a qualifying interrupt");

    stop_wake_a: assert property (@(posedge clk) disable iff (!reset_n)
        core_standby && irq_sync_reg >= stop_level_reg |=> !core_standby && wake_pulse)
        else $error("qualifying interrupt did not wake the core");

    bkpt_trap_a: assert property (@(posedge clk) disable iff (!reset_n)
        instr_done && instr_opcode[15:3] == 13'h0909 |=>
        exc_req && bkpt_ack && exc_vector == 8'h04)
        else $error("breakpoint opcode not trapped");

    illegal_trap_a: assert property (@(posedge clk) disable iff (!reset_n)
        instr_done && !instr_legal && !bkpt_hit && !aline_hit && !fline_hit |=>
        exc_req && !bkpt_ack && exc_vector == 8'h04)
        else $error("illegal opcode not trapped");

    line_vector_a: assert property (@(posedge clk) disable iff (!reset_n)
        instr_done && instr_opcode[15:12] == 4'ha |=> exc_req && exc_vector == 8'h0a)
        else $error("A-line opcode used wrong vector");

    trace_every_a: assert property (@(posedge clk) disable iff (!reset_n)
        instr_done && instr_legal && !bkpt_hit && !aline_hit && !fline_hit &&
        trace_mode == trace_all |=> exc_req && exc_vector == 8'h09)
        else $error("trace missing after instruction");

    trace_flow_a: assert property (@(posedge clk) disable iff (!reset_n)
        instr_done && instr_legal && !bkpt_hit && !aline_hit && !fline_hit &&
        trace_mode == trace_flow && !instr_flow_change |=> !exc_req)
        else $error("flow trace fired on straight-line instruction");

    trace_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        instr_done && instr_legal && !bkpt_hit && !aline_hit && !fline_hit &&
        trace_mode == trace_off |=> !exc_req)
        else $error("trace fired while tracing off");

    stop_cycle_c: cover property (@(posedge clk) disable iff (!reset_n)
        low_power_stop_instr ##1 core_standby [*3] ##[1:20] wake_pulse);
    flow_trace_c: cover property (@(posedge clk) disable iff (!reset_n)
        instr_done && trace_mode == trace_flow && instr_flow_change ##1 exc_req);
    bkpt_c: cover property (@(posedge clk) disable iff (!reset_n) bkpt_ack);
    fline_c: cover property (@(posedge clk) disable iff (!reset_n)
        exc_req && exc_vector == 8'h0b);

endmodule
`default_nettype wire

// >>> src/ctt_table_interp.sv
`timescale 1ns/1ps
`default_nettype none
`include "ctt_defines.svh"

module ctt_table_interp
    import ctt_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // request
    input wire logic start,
    input wire ctt_tbl_variant_t variant,
    input wire logic [15:0] y0,
    input wire logic [15:0] y1,
    input wire logic [7:0] frac,
    // answer
    output logic [15:0] result,
    output logic done
);

    logic is_signed;
    logic do_round;
    logic signed [17:0] diff;
    logic signed [26:0] prod;
    logic signed [26:0] acc;
    logic [15:0] result_next;

    // sign or zero extension of a table entry
    function automatic logic [17:0] ext18(input logic [15:0] v, input logic sgn);
        ext18 = {{2{sgn & v[15]}}, v};
    endfunction

    always_comb
    begin
        is_signed = (variant == table_interp_signed_round) ||
            (variant == table_interp_signed_noround);
        do_round = (variant == table_interp_signed_round) ||
            (variant == table_interp_unsigned_round);
        diff = $signed(ext18(y1, is_signed)) - $signed(ext18(y0, is_signed));
        prod = diff * $signed({1'b0, frac});
        acc = $signed({{1{1'b0}}, ext18(y0, is_signed), 8'h00}) + prod;
        // round to nearest only when asked
        if (do_round)
        begin
            acc = acc + $signed(`CTT_ROUND_HALF);
        end
        result_next = acc[`CTT_FRAC_POS +: 16];
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            result <= `CTT_DATA_RESET;
        end
        else if (start)
        begin
            result <= result_next;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            done <= 1'b0;
        end
        else
        begin
            done <= start;
        end
    end

    interp_zero_frac_a: assert property (@(posedge clk) disable iff (!reset_n)
        start && frac == 8'h00 |=> done && result == $past(y0))
        else $error("zero fraction did not return the first sample");

endmodule
`default_nettype wire
